// ---- rtl/pct_ones_acc.sv ----
`timescale 1ns/1ps
// Ones accumulator: counts set bits of each sampled byte, two-stage pipeline
module pct_ones_acc
  import pct_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sample_valid,
  input  wire logic [7:0] sample_byte,
  input  wire logic       dump,
  output logic      [7:0] acc
);

  logic [3:0] ones_r;
  logic       ones_vld_r;
  logic [7:0] acc_r;
  logic [3:0] ones_nxt;
  logic [7:0] acc_nxt;

  // Whole byte counted, all eight bits of the sample
  always_comb begin
    ones_nxt = 4'h0;
    for (int i = 0; i < 8; i++) begin
      ones_nxt = ones_nxt + {3'h0, sample_byte[i]};
    end
  end

  // Carry dropped on purpose: the sum wraps within eight bits
  assign acc_nxt = acc_r + {4'h0, ones_r};

  // Count and add in separate cycles so each stage stays short
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ones_r     <= 4'h0;
      ones_vld_r <= 1'b0;
    end else begin
      ones_r     <= ones_nxt;
      ones_vld_r <= sample_valid;
    end
  end

  // Dump clears the sum; a count in flight is kept for the new frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= 8'h00;
    end else if (dump) begin
      acc_r <= ones_vld_r ? {4'h0, ones_r} : 8'h00;
    end else if (ones_vld_r) begin
      acc_r <= acc_nxt;
    end
  end

  assign acc = acc_r;

endmodule

// ---- rtl/pct_palette_ctrl.sv ----
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
// Palette control and self-test registers behind an APB slave
module pct_palette_ctrl
  import pct_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hsync_in_n,
  input  wire logic        vsync_in_n,
  input  wire logic        blank_in_n,
  input  wire logic        pass_through_in,
  input  wire logic        comparator_in,
  input  wire logic        pixel_valid,
  input  wire logic [7:0]  palette_red,
  input  wire logic [7:0]  palette_green,
  input  wire logic [7:0]  palette_blue,
  output logic             horizontal_sync_output,
  output logic             vertical_sync_output,
  output logic             external_select_output,
  output logic             split_transfer_enable,
  output logic             nibble_mode_enable,
  output logic             pedestal_enable,
  output logic             green_sync_enable,
  output logic      [3:0]  comparator_select
);

  // Pin synchronisers, two stages each
  logic [1:0] hs_sync_r;
  logic [1:0] vs_sync_r;
  logic [1:0] bl_sync_r;
  logic [1:0] pt_sync_r;
  logic [1:0] cmp_sync_r;
  logic       vs_prev_r;
  logic       bl_prev_r;

  // Software-visible state
  logic [7:0] ctrl_r;
  pct_chan_t  chan_r;
  pct_chan_t  chan_nxt;
  logic [3:0] cmp_field_r;
  logic       cmp_result_r;
  logic [7:0] acc_res_r [3];

  // Bus answer flops
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  // Output flops
  logic hs_out_r;
  logic vs_out_r;
  logic sel_out_r;
  logic split_r;
  logic nib_r;
  logic ped_r;
  logic gsync_r;

  // Decode wires
  wire logic       setup_ph;
  wire logic       done_ph;
  wire logic       hit_ctrl;
  wire logic       hit_test;
  wire logic       wr_ctrl;
  wire logic       wr_test;
  wire logic       rd_test;
  wire logic       pass_thru;
  wire logic       vs_fall;
  wire logic       bl_fall;
  wire logic       acc_mode;
  wire logic [1:0] acc_idx;
  wire logic [7:0] acc_byte;
  wire logic [7:0] acc_val;
  wire logic [7:0] test_rd;
  wire logic [7:0] rd_mux;

  // Only the second stage of each synchroniser is read below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_sync_r  <= 2'h3;
      vs_sync_r  <= 2'h3;
      bl_sync_r  <= 2'h3;
      pt_sync_r  <= 2'h0;
      cmp_sync_r <= 2'h0;
    end else begin
      hs_sync_r  <= {hs_sync_r[0], hsync_in_n};
      vs_sync_r  <= {vs_sync_r[0], vsync_in_n};
      bl_sync_r  <= {bl_sync_r[0], blank_in_n};
      pt_sync_r  <= {pt_sync_r[0], pass_through_in};
      cmp_sync_r <= {cmp_sync_r[0], comparator_in};
    end
  end

  // Edge history on synchronised vsync and blank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vs_prev_r <= 1'b1;
      bl_prev_r <= 1'b1;
    end else begin
      vs_prev_r <= vs_sync_r[1];
      bl_prev_r <= bl_sync_r[1];
    end
  end

  // Only the dedicated vsync pin marks a frame, never composite sync
  assign vs_fall   = vs_prev_r & ~vs_sync_r[1];
  // Strobe for the comparator is the start of blanking
  assign bl_fall   = bl_prev_r & ~bl_sync_r[1];
  assign pass_thru = pt_sync_r[1];

  // APB phase decode
  assign setup_ph = psel & ~penable;
  assign done_ph  = psel & penable & pready_r;
  assign hit_ctrl = (paddr == PCT_ADDR_CTRL);
  assign hit_test = (paddr == PCT_ADDR_TEST);
  assign wr_ctrl  = done_ph & pwrite & hit_ctrl;
  assign wr_test  = done_ph & pwrite & hit_test;
  assign rd_test  = done_ph & ~pwrite & hit_test;

  // Ones accumulation runs only on channels 4..6
  assign acc_mode = chan_r[2] & (chan_r != PCT_CH_ANALOG);
  assign acc_idx  = chan_r[1:0];
  assign acc_byte = (acc_idx == 2'h0) ? palette_red :
                    (acc_idx == 2'h1) ? palette_green : palette_blue;

  // Test port read data by channel
  assign test_rd =
    (chan_r == PCT_CH_PAL_RED) ? palette_red   :
    (chan_r == PCT_CH_PAL_GRN) ? palette_green :
    (chan_r == PCT_CH_PAL_BLU) ? palette_blue  :
    (chan_r == PCT_CH_ID)      ? PCT_ID_CODE   :
    (chan_r == PCT_CH_ANALOG)  ? {cmp_field_r, cmp_result_r, chan_r} :
                                 acc_res_r[acc_idx];

  assign rd_mux = hit_ctrl ? ctrl_r : (hit_test ? test_rd : 8'h00);

  pct_ones_acc u_acc (
    .clk          (pclk),
    .rst_n        (presetn),
    .sample_valid (pixel_valid & acc_mode),
    .sample_byte  (acc_byte),
    .dump         (vs_fall),
    .acc          (acc_val)
  );

  // Registered zero-wait answer: ready rises in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph & ~(hit_ctrl | hit_test);
      if (setup_ph && !pwrite) begin
        // Palette bytes held steady by the host for the read
        prdata_r <= {24'h00_0000, rd_mux};
      end
    end
  end

  // Control register; reserved bit 6 is stored but steers nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= PCT_CTL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata[7:0];
    end
  end

  // Next channel: read post-increment and per-frame step
  always_comb begin
    chan_nxt = chan_r;
    if (wr_test) begin
      chan_nxt = pct_chan_t'(pwdata[PCT_TST_CH_MSB:PCT_TST_CH_LSB]);
    end else if (rd_test) begin
      unique case (chan_r)
        PCT_CH_PAL_RED: chan_nxt = PCT_CH_PAL_GRN;
        PCT_CH_PAL_GRN: chan_nxt = PCT_CH_PAL_BLU;
        PCT_CH_PAL_BLU: chan_nxt = PCT_CH_PAL_RED;
        PCT_CH_ID:      chan_nxt = PCT_CH_PAL_RED;
        default:        chan_nxt = chan_r;
      endcase
    end else if (vs_fall && acc_mode) begin
      unique case (chan_r)
        PCT_CH_ACC_RED: chan_nxt = PCT_CH_ACC_GRN;
        PCT_CH_ACC_GRN: chan_nxt = PCT_CH_ACC_BLU;
        default:        chan_nxt = PCT_CH_ACC_RED;
      endcase
    end
  end

  // Test register control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_r      <= pct_chan_t'(PCT_CH_RESET);
      cmp_field_r <= PCT_CMP_RESET;
    end else begin
      chan_r <= chan_nxt;
      if (wr_test) begin
        cmp_field_r <= pwdata[PCT_TST_CMP_MSB:PCT_TST_CMP_LSB];
      end
    end
  end

  // Frame result per colour, captured before the accumulator clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_res_r[0] <= 8'h00;
      acc_res_r[1] <= 8'h00;
      acc_res_r[2] <= 8'h00;
    end else if (vs_fall && acc_mode) begin
      acc_res_r[acc_idx] <= acc_val;
    end
  end

  // Comparator caught only at blank start; software cannot write it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_result_r <= 1'b0;
    end else if (bl_fall && chan_r == PCT_CH_ANALOG) begin
      cmp_result_r <= cmp_sync_r[1];
    end
  end

  // Sync outputs: inputs are active-low, so active-high means invert
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_out_r <= 1'b0;
      vs_out_r <= 1'b0;
    end else if (pass_thru) begin
      hs_out_r <= hs_sync_r[1];
      vs_out_r <= vs_sync_r[1];
    end else begin
      hs_out_r <= hs_sync_r[1] ^ ctrl_r[PCT_CTL_HPOL];
      vs_out_r <= vs_sync_r[1] ^ ctrl_r[PCT_CTL_VPOL];
    end
  end

  // Mode outputs; both enables off when bits 2 and 3 are both set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_out_r <= 1'b0;
      split_r   <= 1'b0;
      nib_r     <= 1'b0;
      ped_r     <= 1'b0;
      gsync_r   <= 1'b0;
    end else begin
      sel_out_r <= ~pass_thru & ctrl_r[PCT_CTL_SEL];
      split_r   <= ctrl_r[PCT_CTL_SPLIT] & ~ctrl_r[PCT_CTL_NIB];
      nib_r     <= ctrl_r[PCT_CTL_NIB] & ~ctrl_r[PCT_CTL_SPLIT];
      ped_r     <= ctrl_r[PCT_CTL_PED];
      gsync_r   <= ctrl_r[PCT_CTL_GSYNC];
    end
  end

  assign prdata                 = prdata_r;
  assign pready                 = pready_r;
  assign pslverr                = pslverr_r;
  assign horizontal_sync_output = hs_out_r;
  assign vertical_sync_output   = vs_out_r;
  assign external_select_output = sel_out_r;
  assign split_transfer_enable  = split_r;
  assign nibble_mode_enable     = nib_r;
  assign pedestal_enable        = ped_r;
  assign green_sync_enable      = gsync_r;
  // Field drives the analog comparator muxes directly
  assign comparator_select      = cmp_field_r;

endmodule

// ---- shared/pct_pkg.sv ----
package pct_pkg;

  // Register byte addresses on the APB
  localparam logic [11:0] PCT_ADDR_CTRL = 12'h000;
  localparam logic [11:0] PCT_ADDR_TEST = 12'h004;

  // Control register field positions
  localparam int PCT_CTL_HPOL  = 0;
  localparam int PCT_CTL_VPOL  = 1;
  localparam int PCT_CTL_SPLIT = 2;
  localparam int PCT_CTL_NIB   = 3;
  localparam int PCT_CTL_PED   = 4;
  localparam int PCT_CTL_GSYNC = 5;
  localparam int PCT_CTL_SEL   = 7;

  // Control register reset value: both polarity bits set
  localparam logic [7:0] PCT_CTL_RESET = 8'h03;

  // Test register field positions
  localparam int PCT_TST_CH_LSB  = 0;
  localparam int PCT_TST_CH_MSB  = 2;
  localparam int PCT_TST_RESULT  = 3;
  localparam int PCT_TST_CMP_LSB = 4;
  localparam int PCT_TST_CMP_MSB = 7;

  // Test register reset values
  localparam logic [2:0] PCT_CH_RESET  = 3'h0;
  localparam logic [3:0] PCT_CMP_RESET = 4'h0;

  // Channel select codes
  typedef enum logic [2:0] {
    PCT_CH_PAL_RED = 3'h0,
    PCT_CH_PAL_GRN = 3'h1,
    PCT_CH_PAL_BLU = 3'h2,
    PCT_CH_ID      = 3'h3,
    PCT_CH_ACC_RED = 3'h4,
    PCT_CH_ACC_GRN = 3'h5,
    PCT_CH_ACC_BLU = 3'h6,
    PCT_CH_ANALOG  = 3'h7
  } pct_chan_t;

  // Comparison field codes
  localparam logic [3:0] PCT_CMP_R_B   = 4'ha;
  localparam logic [3:0] PCT_CMP_R_REF = 4'h9;
  localparam logic [3:0] PCT_CMP_G_B   = 4'h6;
  localparam logic [3:0] PCT_CMP_G_REF = 4'h5;

  // Identification code; the value is arbitrary
  localparam logic [7:0] PCT_ID_CODE = 8'h5a;

endpackage

// ---- test/pct_host.sv ----
`timescale 1ns/1ps
// Host model: APB master holding each request until ready, for at most 20 cycles
module pct_host (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic      [11:0] paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Bounded wait so a dead slave cannot hang the run
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] r, output logic e, output logic ok);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    ok = (pready === 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// ---- test/pct_palette_ctrl_assertions.sv ----
`timescale 1ns/1ps
// Port checks for the control and test registers
module pct_palette_ctrl_assertions
  import pct_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        hsync_in_n,
  input wire logic        pass_through_in,
  input wire logic        horizontal_sync_output,
  input wire logic        external_select_output,
  input wire logic        split_transfer_enable,
  input wire logic        nibble_mode_enable,
  input wire logic        pedestal_enable,
  input wire logic        green_sync_enable,
  input wire logic [3:0]  comparator_select
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus phases; a write lands at the edge that ends the access
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr(logic [11:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  a_ready_next: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  // An error only ever comes on an address outside the two registers, high or low
  a_err_unmapped: assert property (pslverr |->
    pready && paddr != PCT_ADDR_CTRL && paddr != PCT_ADDR_TEST)
    else $error("error on mapped address");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  // Mode pins follow the stored word one edge after it lands
  a_split_decode: assert property (s_wr(PCT_ADDR_CTRL) |=> ##1
    split_transfer_enable == ($past(pwdata[2], 2) && !$past(pwdata[3], 2)))
    else $error("split enable wrong");
  a_nibble_decode: assert property (s_wr(PCT_ADDR_CTRL) |=> ##1
    nibble_mode_enable == ($past(pwdata[3], 2) && !$past(pwdata[2], 2)))
    else $error("nibble enable wrong");
  a_ped_green: assert property (s_wr(PCT_ADDR_CTRL) |=> ##1
    {green_sync_enable, pedestal_enable} == $past(pwdata[5:4], 2))
    else $error("pedestal or green sync wrong");
  a_cmp_field: assert property (s_wr(PCT_ADDR_TEST) |=>
    comparator_select == $past(pwdata[7:4]))
    else $error("comparison field wrong");
  // Pin passes a two-flop synchroniser and one register
  a_sel_pass: assert property (pass_through_in [*4] |-> !external_select_output)
    else $error("select high in pass-through");
  a_sync_pass: assert property ((pass_through_in && hsync_in_n) [*4] |->
    horizontal_sync_output)
    else $error("pass-through sync altered");
endmodule

bind pct_palette_ctrl pct_palette_ctrl_assertions u_chk (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr,
  .hsync_in_n, .pass_through_in, .horizontal_sync_output, .external_select_output,
  .split_transfer_enable, .nibble_mode_enable, .pedestal_enable, .green_sync_enable,
  .comparator_select
);

// ---- test/pct_palette_ctrl_test.sv ----
`timescale 1ns/1ps
// Self-checking bench for the control and test registers
module pct_palette_ctrl_test
  import pct_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr;
  logic        psel, penable, pwrite, pready, pslverr, last_err;
  logic [31:0] pwdata, prdata, outs;
  logic        hs_n = 1'b1, vs_n = 1'b1, blank_n = 1'b1, pass = 1'b0, cmp_in = 1'b0;
  logic        pv = 1'b0, hso, vso, sel, spl, nib, ped, gsy;
  logic [7:0]  red = 8'h00, grn = 8'h00, blu = 8'h00;
  logic [3:0]  csel;
  int          err_count = 0, checks = 0;

  always #2.5 pclk = ~pclk;
  assign outs = {25'h0, sel, gsy, ped, nib, spl, vso, hso};

  pct_palette_ctrl dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hsync_in_n(hs_n), .vsync_in_n(vs_n), .blank_in_n(blank_n), .pass_through_in(pass),
    .comparator_in(cmp_in), .pixel_valid(pv), .palette_red(red), .palette_green(grn),
    .palette_blue(blu), .horizontal_sync_output(hso), .vertical_sync_output(vso),
    .external_select_output(sel), .split_transfer_enable(spl), .nibble_mode_enable(nib),
    .pedestal_enable(ped), .green_sync_enable(gsy), .comparator_select(csel)
  );
  pct_host host (
    .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata)
  );

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("errors=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // A hung transfer counts as a mismatch and ends the run
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    logic ok;
    host.xfer(w, a, d, r, last_err, ok);
    if (!ok) begin
      err_count++;
      complete_run;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    cmp(r, e);
  endtask

  // Defaults, a stray address, every control bit, then pass-through
  task automatic t_control;
    logic [7:0] v;
    rd(PCT_ADDR_CTRL, 32'h03);
    rd(12'h008, 32'h0);
    cmp({31'h0, last_err}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      v = {i[0], i[1], i[1], i[0], i[1], i[0], i[1], i[0]};
      wr(PCT_ADDR_CTRL, v);
      rd(PCT_ADDR_CTRL, {24'h0, v});
      cmp(outs, {25'h0, i[0], i[1], i[0], i == 2, i == 1, !i[1], !i[0]});
      // Active syncs at the pins must come out with the chosen polarity
      hs_n <= 1'b0;
      vs_n <= 1'b0;
      repeat (4) @(posedge pclk);
      cmp({30'h0, vso, hso}, {30'h0, i[1], i[0]});
      hs_n <= 1'b1;
      vs_n <= 1'b1;
    end
    pass <= 1'b1;
    repeat (5) @(posedge pclk);
    cmp(outs, 32'h33);
    pass <= 1'b0;
    wr(PCT_ADDR_CTRL, PCT_CTL_RESET);
  endtask
  // Palette held still over each read while reads walk the colours
  task automatic t_dataflow;
    red <= 8'h11;
    grn <= 8'h22;
    blu <= 8'h33;
    wr(PCT_ADDR_TEST, 8'h01);
    rd(PCT_ADDR_TEST, 32'h22);
    rd(PCT_ADDR_TEST, 32'h33);
    rd(PCT_ADDR_TEST, 32'h11);
    wr(PCT_ADDR_TEST, 8'h03);
    rd(PCT_ADDR_TEST, {24'h0, PCT_ID_CODE});
    for (int k = 0; k < 5; k++) begin
      rd(PCT_ADDR_TEST, 32'h11 * (k % 3 + 1));
    end
  endtask
  // Samples for n cycles, drained, then a vertical sync fall
  task automatic frame(input int n);
    pv <= 1'b1;
    repeat (n) @(posedge pclk);
    pv <= 1'b0;
    repeat (4) @(posedge pclk);
    vs_n <= 1'b0;
    repeat (6) @(posedge pclk);
    vs_n <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
  // Red sum of 320 wraps to 64; channel steps and wraps to red
  task automatic t_ones;
    red <= 8'hff;
    grn <= 8'h41;
    blu <= 8'h0f;
    wr(PCT_ADDR_TEST, 8'h04);
    frame(40);
    frame(10);
    frame(3);
    rd(PCT_ADDR_TEST, 32'h40);
    wr(PCT_ADDR_TEST, 8'h05);
    rd(PCT_ADDR_TEST, 32'h14);
    wr(PCT_ADDR_TEST, 8'h06);
    rd(PCT_ADDR_TEST, 32'h0c);
  endtask
  // Every comparison code; the written result bit must not stick
  task automatic t_analog;
    logic [3:0] code [4] = '{PCT_CMP_R_B, PCT_CMP_R_REF, PCT_CMP_G_B, PCT_CMP_G_REF};
    for (int i = 0; i < 4; i++) begin
      cmp_in <= !i[0];
      wr(PCT_ADDR_TEST, {code[i], i[0], 3'h7});
      cmp({28'h0, csel}, {28'h0, code[i]});
      blank_n <= 1'b0;
      repeat (6) @(posedge pclk);
      blank_n <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(PCT_ADDR_TEST, {24'h0, code[i], !i[0], 3'h7});
    end
    wr(PCT_ADDR_TEST, 8'h00);
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_control();
    t_dataflow();
    t_ones();
    t_analog();
    complete_run();
  end
endmodule
